// file: rtl/mpg_pkg.sv
// Package for the multi-group PWM generator: register map, field
// positions, reset values and carrier types.
// Assumes a single 40 MHz clock and a plain strobe register port.
package mpg_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_GROUPS     = 4;
    localparam int OUTS_PER_GROUP = 4;
    localparam int NUM_OUTS       = NUM_GROUPS * OUTS_PER_GROUP;
    localparam int PAIRS_PER_GRP  = 2;
    localparam int CNT_W          = 16;
    localparam int ADDR_W         = 6;
    localparam int DATA_W         = 32;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h08;
    // Duty registers: one per channel slot (group*2 + pair),
    // eight words from this base
    localparam logic [ADDR_W-1:0] OFS_DUTY0  = 6'h10;
    localparam int NUM_DUTY = NUM_GROUPS * PAIRS_PER_GRP;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_EDGE_BIT   = 1;
    localparam int CTRL_DOUBLE_BIT = 2;
    localparam int CTRL_NPAIR_LSB  = 4;
    localparam logic [DATA_W-1:0] CTRL_RST     = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  PERIOD_RST   = 16'h0100;
    localparam logic [CNT_W-1:0]  DUTY_RST     = 16'h0000;

    // Status fields
    localparam int STAT_DIR_BIT = 0;
    localparam int STAT_CNT_LSB = 16;

    typedef struct packed {
        logic                  enable;
        logic                  edge_mode;
        logic                  double_upd;
        logic [NUM_GROUPS-1:0] nonpaired;
    } mpg_cfg_s;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mpg_req_s;

endpackage

// file: rtl/mpg_duty_mem.sv
// Duty value store: eight words, written by software, registered read.
// Assumes one clock; reads take one cycle.
`timescale 1ns/10ps
`default_nettype none
module mpg_duty_mem
    import mpg_pkg::*;
#(
    parameter int DEPTH = NUM_DUTY,
    parameter int WIDTH = CNT_W
) (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [WIDTH-1:0]         rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= WIDTH'(DUTY_RST);
            end
            rd_data <= WIDTH'(DUTY_RST);
        end else begin
            if (wr_en) begin
                mem[wr_idx] <= wr_data;
            end
            rd_data <= mem[rd_idx];
        end
    end
endmodule // mpg_duty_mem
`default_nettype wire

// file: rtl/mpg_top.sv
// Sixteen-output PWM generator in four groups of four, with shadowed
// duty values and a register port.
// Assumes a synchronous master that never issues read and write together.
//
// Behaviour
// - Sixteen outputs in four groups of four
// - Each group drives two pairs
// - Center- or edge-aligned waveform selectable
// - Paired outputs are complementary
// - Nonpaired mode selectable per group
// - Center mode offers single or double update
// - Single update: load once per period
// - Double update: also load at midpoint
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module mpg_top
    import mpg_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    output logic      [NUM_OUTS-1:0] pwm_out
);
    localparam int IDX_W = $clog2(NUM_DUTY);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    function automatic logic is_duty(input logic [ADDR_W-1:0] a);
        return (a >= OFS_DUTY0) && (a < OFS_DUTY0 + 6'(NUM_DUTY * 4))
            && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [IDX_W-1:0] duty_idx(
        input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - OFS_DUTY0;
        return d[IDX_W+1:2];
    endfunction

    mpg_req_s req;
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr,
                   wdata: reg_wdata};

    mpg_cfg_s         cfg, next_cfg;
    logic [CNT_W-1:0] period_shadow, next_period_shadow;

    always_comb begin
        next_cfg           = cfg;
        next_period_shadow = period_shadow;
        if (req.wr && req.addr == OFS_CTRL) begin
            next_cfg.enable     = req.wdata[CTRL_EN_BIT];
            next_cfg.edge_mode  = req.wdata[CTRL_EDGE_BIT];
            next_cfg.double_upd = req.wdata[CTRL_DOUBLE_BIT];
            next_cfg.nonpaired  =
                req.wdata[CTRL_NPAIR_LSB +: NUM_GROUPS];
        end
        if (req.wr && req.addr == OFS_PERIOD) begin
            next_period_shadow = req.wdata[CNT_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg.enable     <= CTRL_RST[CTRL_EN_BIT];
            cfg.edge_mode  <= CTRL_RST[CTRL_EDGE_BIT];
            cfg.double_upd <= CTRL_RST[CTRL_DOUBLE_BIT];
            cfg.nonpaired  <= CTRL_RST[CTRL_NPAIR_LSB +: NUM_GROUPS];
            period_shadow <= PERIOD_RST;
        end else begin
            cfg           <= next_cfg;
            period_shadow <= next_period_shadow;
        end
    end

    // ------------------------------------------------------------
    // Shadow duty store
    // ------------------------------------------------------------
    // Software writes only the shadow; the active set is refreshed by
    // a scan that runs at each update point, so a half-written value
    // never reaches a comparator mid-period.
    logic [IDX_W-1:0] scan_idx, next_scan_idx;
    logic             scan_busy, next_scan_busy;
    logic             scan_valid, next_scan_valid;
    logic [IDX_W-1:0] scan_wr_idx, next_scan_wr_idx;
    logic [CNT_W-1:0] shadow_rd;

    mpg_duty_mem #(
        .DEPTH (NUM_DUTY),
        .WIDTH (CNT_W)
    ) u_duty (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (req.wr && is_duty(req.addr)),
        .wr_idx  (duty_idx(req.addr)),
        .wr_data (req.wdata[CNT_W-1:0]),
        .rd_idx  (scan_idx),
        .rd_data (shadow_rd)
    );

    // ------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt, next_cnt;
    logic             cnt_down, next_cnt_down;
    logic [CNT_W-1:0] period, next_period;
    logic             upd_point;

    always_comb begin
        next_cnt      = cnt;
        next_cnt_down = cnt_down;
        next_period   = period;
        upd_point     = 1'b0;
        if (!cfg.enable) begin
            next_cnt      = '0;
            next_cnt_down = 1'b0;
            upd_point     = 1'b1;
            next_period   = period_shadow;
        end else if (cfg.edge_mode) begin
            next_cnt_down = 1'b0;
            if (cnt >= period - 16'h0001) begin
                next_cnt    = '0;
                next_period = period_shadow;
                upd_point   = 1'b1;
            end else begin
                next_cnt = cnt + 16'h0001;
            end
        end else if (!cnt_down) begin
            if (cnt >= period) begin
                next_cnt_down = 1'b1;
                next_cnt      = cnt - 16'h0001;
                upd_point     = cfg.double_upd;
            end else begin
                next_cnt = cnt + 16'h0001;
            end
        end else if (cnt == '0 || cnt > period) begin
            next_cnt_down = 1'b0;
            next_cnt      = 16'h0001;
            next_period   = period_shadow;
            upd_point     = 1'b1;
        end else begin
            next_cnt = cnt - 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt      <= '0;
            cnt_down <= 1'b0;
            period   <= PERIOD_RST;
        end else begin
            cnt      <= next_cnt;
            cnt_down <= next_cnt_down;
            period   <= next_period;
        end
    end

    // ------------------------------------------------------------
    // Active duty load scan
    // ------------------------------------------------------------
    // Eight shadow words are copied over eight cycles after the update
    // point; the period must therefore exceed eight counts.
    logic [CNT_W-1:0] active [NUM_DUTY];

    always_comb begin
        next_scan_idx    = scan_idx;
        next_scan_busy   = scan_busy;
        next_scan_valid  = 1'b0;
        next_scan_wr_idx = scan_idx;
        if (upd_point && !scan_busy) begin
            next_scan_busy = 1'b1;
            next_scan_idx  = '0;
        end else if (scan_busy) begin
            next_scan_valid = 1'b1;
            next_scan_idx   = scan_idx + 1'b1;
            if (scan_idx == IDX_W'(NUM_DUTY - 1)) begin
                next_scan_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scan_idx    <= '0;
            scan_busy   <= 1'b0;
            scan_valid  <= 1'b0;
            scan_wr_idx <= '0;
            for (int i = 0; i < NUM_DUTY; i++) begin
                active[i] <= DUTY_RST;
            end
        end else begin
            scan_idx    <= next_scan_idx;
            scan_busy   <= next_scan_busy;
            scan_valid  <= next_scan_valid;
            scan_wr_idx <= next_scan_wr_idx;
            if (scan_valid) begin
                active[scan_wr_idx] <= shadow_rd;
            end
        end
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    // Slot 2g+p drives pair p of group g; in nonpaired mode it drives
    // lane 2p and lane 2p+1 is taken from the same slot inverted in
    // polarity compare, giving an independent low-side window.
    logic [NUM_OUTS-1:0] next_pwm;

    always_comb begin
        next_pwm = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            for (int p = 0; p < PAIRS_PER_GRP; p++) begin
                logic hi;
                logic lo;
                hi = cfg.enable && (cnt < active[g*2+p]);
                lo = cfg.enable && (cnt >= (period - active[g*2+p]));
                next_pwm[g*4+p*2] = hi;
                if (cfg.nonpaired[g]) begin
                    next_pwm[g*4+p*2+1] = lo;
                end else begin
                    next_pwm[g*4+p*2+1] = cfg.enable && !hi;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pwm_out <= '0;
        end else begin
            pwm_out <= next_pwm;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        if (req.rd) begin
            case (req.addr)
                OFS_CTRL: begin
                    next_rdata[CTRL_EN_BIT]     = cfg.enable;
                    next_rdata[CTRL_EDGE_BIT]   = cfg.edge_mode;
                    next_rdata[CTRL_DOUBLE_BIT] = cfg.double_upd;
                    next_rdata[CTRL_NPAIR_LSB +: NUM_GROUPS] =
                        cfg.nonpaired;
                end
                OFS_PERIOD: next_rdata[CNT_W-1:0] = period_shadow;
                OFS_STATUS: begin
                    next_rdata[STAT_DIR_BIT]          = cnt_down;
                    next_rdata[STAT_CNT_LSB +: CNT_W] = cnt;
                end
                default: begin
                    if (is_duty(req.addr)) begin
                        next_rdata[CNT_W-1:0] =
                            active[duty_idx(req.addr)];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule // mpg_top
`default_nettype wire

// file: testbench/mpg_stage_model.sv
// Power stage model: integrates the on time of every switch.
// Assumes the bench pulses clr, then holds meas for a window.
`timescale 1ns/10ps
`default_nettype none
module mpg_stage_model
    import mpg_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                clr,
    input  wire logic                meas,
    input  wire logic [NUM_OUTS-1:0] pwm_out,
    output logic      [15:0]         on_cnt [NUM_OUTS]
);
    // ----
    // On-time counters, one per switch
    // ----
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_OUTS; i++) begin
            if (clr)
                on_cnt[i] <= 16'h0000;
            else if (meas && pwm_out[i] === 1'b1)
                on_cnt[i] <= on_cnt[i] + 16'h0001;
        end
    end
endmodule // mpg_stage_model
`default_nettype wire

// file: testbench/mpg_top_sva.sv
// Checker for the generator's register port and outputs.
// Assumes it is bound to mpg_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module mpg_top_sva
    import mpg_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                sys_rst,
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic [DATA_W-1:0]   reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [DATA_W-1:0]   reg_rdata,
    input wire logic [NUM_OUTS-1:0] pwm_out
);
    // ----
    // Shadow of the programmed mode
    // ----
    logic [7:0]  ctrl_q;
    logic [15:0] per_q;
    logic [9:0]  quiet;
    logic        pair_ok;
    wire logic   run;
    // Mode changes apply the cycle after the write, a new period only at a period start, so wait well past one
    assign run = quiet[9] && ctrl_q[0];
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_q <= 8'h00;
            per_q <= PERIOD_RST;
            quiet <= 10'h000;
        end else if (reg_wr && reg_addr == OFS_CTRL) begin
            ctrl_q <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
            quiet <= 10'h000;
        end else if (reg_wr && reg_addr == OFS_PERIOD) begin
            per_q <= reg_wdata[15:0];
            quiet <= 10'h000;
        end else if (!quiet[9]) begin
            quiet <= quiet + 10'h001;
        end
    end
    always_comb begin
        pair_ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (!ctrl_q[4 + i / 2] && pwm_out[2 * i + 1] == pwm_out[2 * i])
                pair_ok = 1'b0;
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd(logic [ADDR_W-1:0] a);
        reg_rd && reg_addr == a;
    endsequence
    a_pair_compl: assert property (run |-> pair_ok)
        else $error("paired outputs not complementary");
    a_off_quiet: assert property (
        quiet[9] && !ctrl_q[0] |-> pwm_out == '0)
        else $error("outputs active while disabled");
    a_rst_clear: assert property ($fell(sys_rst) |-> pwm_out == '0)
        else $error("outputs not cleared by reset");
    a_rd_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr >= 6'h30 |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    a_ctrl_back: assert property (
        s_rd(OFS_CTRL) |=> reg_rdata == {24'h0, ctrl_q})
        else $error("control readback wrong");
    a_edge_count: assert property (
        (run && ctrl_q[1]) and s_rd(OFS_STATUS)
        |=> !reg_rdata[0] && reg_rdata[31:16] < per_q)
        else $error("edge counter out of range");
    a_center_top: assert property (
        (run && !ctrl_q[1]) and s_rd(OFS_STATUS)
        |=> reg_rdata[31:16] <= per_q)
        else $error("center counter above top");
    a_edge_align: assert property (
        run && ctrl_q[1] && $rose(pwm_out[0])
        |-> !$fell(pwm_out[4]))
        else $error("edge pulses not aligned to start");
endmodule // mpg_top_sva
bind mpg_top mpg_top_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out));
`default_nettype wire

// file: testbench/mpg_top_bench.sv
// Bench for mpg_top: programs every mode and measures on times.
// Assumes a 40 MHz clock and the stage model on the outputs.
`timescale 1ns/10ps
`default_nettype none
module mpg_top_bench
    import mpg_pkg::*;
;
    localparam int P = 16;
    logic                ref_clk = 1'b0;
    logic                sys_rst, reg_wr, reg_rd, clr, meas;
    logic                rd_d = 1'b0;
    logic [ADDR_W-1:0]   reg_addr;
    logic [DATA_W-1:0]   reg_wdata, reg_rdata;
    logic [NUM_OUTS-1:0] pwm_out;
    logic [15:0]         on_cnt [NUM_OUTS];
    logic [15:0]         duty [NUM_DUTY];
    logic [32:0]         exp_q [$];
    logic [32:0]         mon_e;
    int                  fail_count = 0, cmp_count = 0, cycles = 0, n;
    integer              seed;
    always #12.5 ref_clk = ~ref_clk;
    mpg_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out));
    mpg_stage_model u_stage (.ref_clk(ref_clk), .clr(clr), .meas(meas),
        .pwm_out(pwm_out), .on_cnt(on_cnt));
    // ----
    // Bus and compare tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Bit 32 of the note marks a read whose value is not compared
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic measure(input int m, input logic [3:0] np);
        int w;
        int e;
        int b;
        w = (m == 2) ? 2 * P : P;
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        meas <= 1'b1;
        repeat (w) @(posedge ref_clk);
        meas <= 1'b0;
        @(posedge ref_clk);
        for (int k = 0; k < NUM_DUTY; k++) begin
            b = 4 * (k / 2) + 2 * (k % 2);
            e = (m == 0) ? 0 : (m == 1) ? duty[k] : 2 * duty[k] - 1;
            chk(32'(on_cnt[b]), 32'(e));
            e = (m == 0 || np[k / 2]) ? e : w - e;
            chk(32'(on_cnt[b + 1]), 32'(e));
        end
    endtask
    task automatic run(input logic [7:0] c, input int m, input logic [3:0] np);
        wr(OFS_CTRL, 32'(c));
        repeat (600) @(posedge ref_clk);
        rd(OFS_CTRL, 33'(c));
        rd(OFS_STATUS, {1'(m != 0), 32'h0});
        measure(m, np);
    endtask
    // Center mode: write slot 0 just after lane 0 falls on the way up,
    // then read it back after the top but before the next bottom
    task automatic mid_upd(input logic [7:0] c, input logic [15:0] d,
                           input logic [32:0] e);
        int t;
        wr(OFS_CTRL, 32'(c));
        repeat (4 * P) @(posedge ref_clk);
        t = 0;
        while (pwm_out[0] !== 1'b1 && t < 80) begin
            @(posedge ref_clk);
            t++;
        end
        while (pwm_out[0] !== 1'b0 && t < 160) begin
            @(posedge ref_clk);
            t++;
        end
        wr(OFS_DUTY0, 32'(d));
        repeat (P - 4) @(posedge ref_clk);
        rd(OFS_DUTY0, e);
    endtask
    task automatic print_verdict;
        $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----
    // Read monitor and hang guard
    // ----
    always @(posedge ref_clk) begin
        if (rd_d) begin
            mon_e = exp_q.pop_front();
            if (!mon_e[32])
                chk(reg_rdata, mon_e[31:0]);
        end
        rd_d <= reg_rd;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            fail_count++;
            print_verdict();
        end
    end
    // ----
    // Main sequence
    // ----
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        clr = 1'b0;
        meas = 1'b0;
        seed = 32'hd271b3cb;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(OFS_CTRL, 33'(CTRL_RST));
        rd(OFS_PERIOD, 33'(PERIOD_RST));
        rd(OFS_DUTY0, 33'(DUTY_RST));
        wr(6'h3c, 32'hffff_ffff);
        rd(6'h3c, 33'h0);
        wr(OFS_PERIOD, 32'(P));
        for (int k = 0; k < NUM_DUTY; k++) begin
            duty[k] = 16'(1 + (($random(seed) & 32'h7fffffff) % (P - 1)));
            wr(ADDR_W'(OFS_DUTY0 + 4 * k), 32'(duty[k]));
        end
        run(8'h43, 1, 4'h4);
        run(8'h01, 2, 4'h0);
        run(8'h05, 2, 4'h0);
        run(8'h00, 0, 4'h0);
        wr(OFS_DUTY0, 32'h2);
        duty[0] = 16'h0002;
        run(8'h03, 1, 4'h0);
        // Write just after a falling edge, far from the next update
        n = 0;
        while (pwm_out[0] !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        while (pwm_out[0] !== 1'b0 && n < 80) begin
            @(posedge ref_clk);
            n++;
        end
        wr(OFS_DUTY0, 32'h9);
        rd(OFS_DUTY0, 33'h2);
        duty[0] = 16'h0009;
        repeat (3 * P) @(posedge ref_clk);
        rd(OFS_DUTY0, 33'h9);
        measure(1, 4'h0);
        // Single update keeps the old value until the bottom
        mid_upd(8'h01, 16'h0004, 33'h9);
        mid_upd(8'h05, 16'h000c, 33'hc);
        repeat (4) @(posedge ref_clk);
        print_verdict();
    end
endmodule // mpg_top_bench
`default_nettype wire
